// *** rtl/pcb_pkg.sv ***
// package for the program counter and bank select block
// assumes a single 10 MHz clock and 8-bit data registers
package pcb_pkg;
    localparam int PCB_ADDR_W = 11;
    localparam int PCB_DATA_ADDR_W = 7;
    localparam logic [10:0] PCB_RESET_VECTOR = 11'h7ff;
    localparam logic [10:0] PCB_PC_ONE = 11'h001;
    // special register offsets within the data space
    localparam logic [4:0] PCB_OFS_INDIRECT = 5'h00;
    localparam logic [4:0] PCB_OFS_TIMER = 5'h01;
    localparam logic [4:0] PCB_OFS_PCLOW = 5'h02;
    localparam logic [4:0] PCB_OFS_STATUS = 5'h03;
    localparam logic [4:0] PCB_OFS_INDEX = 5'h04;
    localparam logic [4:0] PCB_OFS_PORTA = 5'h05;
    localparam logic [4:0] PCB_OFS_PORTB = 5'h06;
    localparam logic [4:0] PCB_OFS_PORTC = 5'h07;
    // field positions
    localparam int PCB_PBANK_LO_POS = 5;
    localparam int PCB_PBANK_HI_POS = 6;
    localparam int PCB_DBANK_LO_POS = 5;
    localparam int PCB_DBANK_HI_POS = 6;
    localparam int PCB_BANKED_BIT = 4;
    // reset values and stack depth
    localparam logic [7:0] PCB_STATUS_RESET = 8'h00;
    localparam logic [7:0] PCB_INDEX_RESET = 8'h80;
    localparam int PCB_STACK_DEPTH = 2;
    // flow control operation codes from the decoder
    typedef enum logic [2:0]
    {
        PCB_OP_SEQ = 3'h0,
        PCB_OP_JUMP = 3'h1,
        PCB_OP_CALL = 3'h2,
        PCB_OP_RET = 3'h3,
        PCB_OP_PCWR = 3'h4
    } pcb_op_t;
endpackage

// *** rtl/pcb_core.sv ***
// program sequencing and data bank address forming
// assumes the decoder supplies flow ops and register writes, synchronous to clk
`timescale 1ns/10ps
`default_nettype none
module pcb_core
    import pcb_pkg::*;
#(
    parameter logic [10:0] RESET_VECTOR = PCB_RESET_VECTOR,
    parameter int STACK_DEPTH = PCB_STACK_DEPTH
)
(
    input wire logic clk,
    input wire logic resetn,
    input wire pcb_op_t flow_op,
    input wire logic [8:0] instr_target,
    input wire logic [7:0] alu_result,
    input wire logic reg_write,
    input wire logic [4:0] reg_num,
    input wire logic indirect_sel,
    output logic [10:0] fetch_addr,
    output logic flush,
    output logic [6:0] data_addr,
    output logic [7:0] status_flags,
    output logic [7:0] index_pointer,
    output logic [7:0] program_counter_low
);
    // the stack is written out for two levels, so any other depth is refused here
    if (STACK_DEPTH != 2)
    begin
        $error("stack depth must be 2");
    end

    logic [10:0] pc_reg;
    logic [10:0] pc_next;
    logic flush_reg;
    logic flush_next;
    logic [10:0] stack_reg [STACK_DEPTH];
    logic [10:0] stack_next [STACK_DEPTH];
    logic [7:0] status_reg;
    logic [7:0] status_next;
    logic [7:0] index_reg;
    logic [7:0] index_next;
    logic [6:0] daddr_reg;
    logic [6:0] daddr_next;
    logic [1:0] pbank;
    logic [1:0] dbank;
    logic [6:0] raw_addr;
    logic live_op;

    // program bank and data bank bits
    assign pbank = {status_reg[PCB_PBANK_HI_POS], status_reg[PCB_PBANK_LO_POS]};
    assign dbank = {index_reg[PCB_DBANK_HI_POS], index_reg[PCB_DBANK_LO_POS]};
    // an op is ignored while its instruction is being flushed
    assign live_op = !flush_reg;

    // program counter, flush and stack next values
    always_comb
    begin
        pc_next = pc_reg + PCB_PC_ONE;
        flush_next = 1'b0;
        stack_next = stack_reg;
        if (live_op)
        begin
            unique case (flow_op)
                PCB_OP_SEQ:
                begin
                    pc_next = pc_reg + PCB_PC_ONE;
                end
                PCB_OP_JUMP:
                begin
                    pc_next = {pbank, instr_target};
                    flush_next = 1'b1;
                end
                PCB_OP_CALL:
                begin
                    // older entry shifts down and is lost when full
                    stack_next[1] = stack_reg[0];
                    stack_next[0] = pc_reg;
                    pc_next = {pbank, 1'b0, instr_target[7:0]};
                    flush_next = 1'b1;
                end
                PCB_OP_RET:
                begin
                    pc_next = stack_reg[0];
                    stack_next[0] = stack_reg[1];
                    flush_next = 1'b1;
                end
                PCB_OP_PCWR:
                begin
                    pc_next = {pbank, 1'b0, alu_result};
                    flush_next = 1'b1;
                end
                default:
                begin
                    pc_next = pc_reg + PCB_PC_ONE;
                end
            endcase
        end
    end

    // sequencing state registers
    always_ff @(posedge clk or negedge resetn)
    begin
        if (!resetn)
        begin
            pc_reg <= RESET_VECTOR;
            flush_reg <= 1'b1;
            stack_reg[0] <= 11'h000;
            stack_reg[1] <= 11'h000;
        end
        else
        begin
            pc_reg <= pc_next;
            flush_reg <= flush_next;
            stack_reg <= stack_next;
        end
    end

    // data address forming and register writes
    always_comb
    begin
        status_next = status_reg;
        index_next = index_reg;
        if (indirect_sel)
        begin
            raw_addr = index_reg[6:0];
        end
        else
        begin
            raw_addr = {dbank, reg_num};
        end
        if (!raw_addr[PCB_BANKED_BIT])
        begin
            daddr_next = {2'h0, raw_addr[4:0]};
        end
        else
        begin
            daddr_next = raw_addr;
        end
        if (live_op && reg_write && !indirect_sel)
        begin
            if (reg_num == PCB_OFS_STATUS)
            begin
                status_next = alu_result;
            end
            if (reg_num == PCB_OFS_INDEX)
            begin
                index_next = alu_result;
            end
        end
    end

    always_ff @(posedge clk or negedge resetn)
    begin
        if (!resetn)
        begin
            status_reg <= PCB_STATUS_RESET;
            index_reg <= PCB_INDEX_RESET;
            daddr_reg <= 7'h00;
        end
        else
        begin
            status_reg <= status_next;
            index_reg <= index_next;
            daddr_reg <= daddr_next;
        end
    end

    // outputs straight from flip-flops
    assign fetch_addr = pc_reg;
    assign flush = flush_reg;
    assign data_addr = daddr_reg;
    assign status_flags = status_reg;
    assign index_pointer = index_reg;
    assign program_counter_low = pc_reg[7:0];

    // sequencing checks; sampled resetn keeps out the release edge, which still resets
    property p_jump_target;
        @(posedge clk) disable iff (!resetn)
        (!flush_reg && flow_op == PCB_OP_JUMP) |=> pc_reg == {$past(pbank), $past(instr_target)};
    endproperty
    a_jump_target: assert property (p_jump_target) else $error("bad jump target");

    property p_call_target;
        @(posedge clk) disable iff (!resetn)
        (!flush_reg && flow_op == PCB_OP_CALL) |=> pc_reg[8] == 1'b0 && flush_reg;
    endproperty
    a_call_target: assert property (p_call_target) else $error("bad call target");

    property p_push;
        @(posedge clk) disable iff (!resetn)
        (!flush_reg && flow_op == PCB_OP_CALL) |=> stack_reg[0] == $past(pc_reg);
    endproperty
    a_push: assert property (p_push) else $error("return address not pushed");

    property p_call_ret;
        @(posedge clk) disable iff (!resetn)
        (!flush_reg && flow_op == PCB_OP_CALL) ##1 1'b1 ##1 (!flush_reg && flow_op == PCB_OP_RET)
        |=> pc_reg == $past(pc_reg, 3);
    endproperty
    a_call_ret: assert property (p_call_ret) else $error("return mismatch");

    property p_seq;
        @(posedge clk) disable iff (!resetn)
        (resetn && (flush_reg || flow_op == PCB_OP_SEQ))
        |=> pc_reg == $past(pc_reg) + PCB_PC_ONE;
    endproperty
    a_seq: assert property (p_seq) else $error("no increment");

    property p_flush_one;
        @(posedge clk) disable iff (!resetn)
        (resetn && flush_reg) |=> !flush_reg;
    endproperty
    a_flush_one: assert property (p_flush_one) else $error("flush too long");

    property p_pcwr;
        @(posedge clk) disable iff (!resetn)
        (!flush_reg && flow_op == PCB_OP_PCWR) |=> pc_reg[7:0] == $past(alu_result) && !pc_reg[8];
    endproperty
    a_pcwr: assert property (p_pcwr) else $error("bad pc write");

    // data addressing checks
    property p_low_shared;
        @(posedge clk) disable iff (!resetn)
        (!indirect_sel && !reg_num[4]) |=> data_addr[6:5] == 2'h0;
    endproperty
    a_low_shared: assert property (p_low_shared) else $error("shared not bank 0");

    property p_direct;
        @(posedge clk) disable iff (!resetn)
        (!indirect_sel && reg_num[4]) |=> data_addr == {$past(dbank), $past(reg_num)};
    endproperty
    a_direct: assert property (p_direct) else $error("bad direct address");

    property p_indirect;
        @(posedge clk) disable iff (!resetn)
        (indirect_sel && index_reg[PCB_BANKED_BIT]) |=> data_addr == $past(index_reg[6:0]);
    endproperty
    a_indirect: assert property (p_indirect) else $error("bad indirect address");

    property p_ind_shared;
        @(posedge clk) disable iff (!resetn)
        (indirect_sel && !index_reg[PCB_BANKED_BIT])
        |=> data_addr == {2'h0, $past(index_reg[4:0])};
    endproperty
    a_ind_shared: assert property (p_ind_shared) else $error("indirect not bank 0");

    // stack, reset and register write checks
    property p_reset_vector;
        @(posedge clk) disable iff (!resetn)
        $rose(resetn) |-> pc_reg == RESET_VECTOR && flush_reg;
    endproperty
    a_reset_vector: assert property (p_reset_vector) else $error("bad reset vector");

    property p_reset_wrap;
        @(posedge clk) disable iff (!resetn)
        $rose(resetn) |=> pc_reg == RESET_VECTOR + PCB_PC_ONE && !flush_reg;
    endproperty
    a_reset_wrap: assert property (p_reset_wrap) else $error("no wrap after reset");

    property p_ret_pop;
        @(posedge clk) disable iff (!resetn)
        (!flush_reg && flow_op == PCB_OP_RET) |=> pc_reg == $past(stack_reg[0]) && flush_reg;
    endproperty
    a_ret_pop: assert property (p_ret_pop) else $error("bad return pop");

    property p_ret_shift;
        @(posedge clk) disable iff (!resetn)
        (!flush_reg && flow_op == PCB_OP_RET) |=> stack_reg[0] == $past(stack_reg[1]);
    endproperty
    a_ret_shift: assert property (p_ret_shift) else $error("stack not moved up");

    property p_overwrite;
        @(posedge clk) disable iff (!resetn)
        (!flush_reg && flow_op == PCB_OP_CALL) |=> stack_reg[1] == $past(stack_reg[0]);
    endproperty
    a_overwrite: assert property (p_overwrite) else $error("stack not shifted");

    property p_stack_hold;
        @(posedge clk) disable iff (!resetn)
        (resetn && (flush_reg || flow_op == PCB_OP_SEQ))
        |=> stack_reg[0] == $past(stack_reg[0]) && stack_reg[1] == $past(stack_reg[1]);
    endproperty
    a_stack_hold: assert property (p_stack_hold) else $error("stack disturbed");

    property p_call_bank;
        @(posedge clk) disable iff (!resetn)
        (!flush_reg && flow_op == PCB_OP_CALL)
        |=> pc_reg == {$past(pbank), 1'b0, $past(instr_target[7:0])};
    endproperty
    a_call_bank: assert property (p_call_bank) else $error("bad call bank");

    property p_pcwr_bank;
        @(posedge clk) disable iff (!resetn)
        (!flush_reg && flow_op == PCB_OP_PCWR) |=> pc_reg[10:9] == $past(pbank);
    endproperty
    a_pcwr_bank: assert property (p_pcwr_bank) else $error("bad pc write bank");

    property p_flow_flush;
        @(posedge clk) disable iff (!resetn)
        (!flush_reg && flow_op inside {PCB_OP_JUMP, PCB_OP_CALL, PCB_OP_RET, PCB_OP_PCWR})
        |=> flush_reg;
    endproperty
    a_flow_flush: assert property (p_flow_flush) else $error("no flush cycle");

    property p_flush_hold;
        @(posedge clk) disable iff (!resetn)
        (resetn && flush_reg)
        |=> status_reg == $past(status_reg) && index_reg == $past(index_reg);
    endproperty
    a_flush_hold: assert property (p_flush_hold) else $error("write in flush");

    property p_status_write;
        @(posedge clk) disable iff (!resetn)
        (!flush_reg && reg_write && !indirect_sel && reg_num == PCB_OFS_STATUS)
        |=> status_reg == $past(alu_result);
    endproperty
    a_status_write: assert property (p_status_write) else $error("status lost");

    property p_index_write;
        @(posedge clk) disable iff (!resetn)
        (!flush_reg && reg_write && !indirect_sel && reg_num == PCB_OFS_INDEX)
        |=> index_reg == $past(alu_result);
    endproperty
    a_index_write: assert property (p_index_write) else $error("index lost");
endmodule
`default_nettype wire

// *** bench/pcb_mem.sv ***
// instruction rom and banked register file as seen from the core
// assumes fetch and data addresses come straight from pcb_core
`timescale 1ns/10ps
`default_nettype none
module pcb_mem
(
    input wire logic [10:0] fetch_addr,
    input wire logic [6:0] data_addr,
    output logic [11:0] instr,
    output logic [7:0] reg_data
);
    // 2048 x 12 rom: each word is made from its address so no two look alike
    always_comb
    begin
        instr = {1'b1, ~fetch_addr};
        reg_data = {1'b0, data_addr} ^ 8'h5a;
    end
endmodule
`default_nettype wire

// *** bench/tb.sv ***
// scenario bench for the program counter and bank select block
// assumes pcb_pkg is compiled first and the core acts on each rising edge
`timescale 1ns/10ps
`default_nettype none
module tb
    import pcb_pkg::*;
;
    logic clk = 1'b0;
    logic resetn = 1'b0;
    pcb_op_t flow_op = PCB_OP_SEQ;
    logic [8:0] instr_target = 9'h000;
    logic [7:0] alu_result = 8'h00;
    logic reg_write = 1'b0;
    logic [4:0] reg_num = 5'h00;
    logic indirect_sel = 1'b0;
    logic [10:0] fetch_addr;
    logic flush;
    logic [6:0] data_addr;
    logic [7:0] status_flags, index_pointer, program_counter_low, reg_data;
    logic [11:0] instr;
    int err_count = 0;
    int tests_run = 0;

    pcb_core dut(.clk(clk), .resetn(resetn), .flow_op(flow_op), .instr_target(instr_target),
        .alu_result(alu_result), .reg_write(reg_write), .reg_num(reg_num),
        .indirect_sel(indirect_sel), .fetch_addr(fetch_addr), .flush(flush),
        .data_addr(data_addr), .status_flags(status_flags), .index_pointer(index_pointer),
        .program_counter_low(program_counter_low));
    pcb_mem mem(.fetch_addr(fetch_addr), .data_addr(data_addr), .instr(instr),
        .reg_data(reg_data));

    // 100 ns period clock
    initial
    begin
        forever #50 clk = ~clk;
    end

    task chk(input string n, input logic [11:0] s, input logic [11:0] e);
        tests_run++;
        if (s !== e)
        begin
            err_count++;
            $display("mismatch %s expected %h seen %h", n, e, s);
        end
    endtask

    // inputs change at the edge; return at the falling edge, before the next rising edge takes them in
    task go(input pcb_op_t op, input logic [8:0] t, input logic [7:0] a, input logic w,
        input logic [4:0] r, input logic i);
        @(posedge clk);
        flow_op <= op;
        instr_target <= t;
        alu_result <= a;
        reg_write <= w;
        reg_num <= r;
        indirect_sel <= i;
        @(negedge clk);
    endtask

    task seq;
        go(PCB_OP_SEQ, 9'h000, 8'h00, 1'b0, 5'h00, 1'b0);
    endtask

    task flow(input pcb_op_t op, input logic [8:0] t, input logic [7:0] a);
        go(op, t, a, 1'b0, 5'h00, 1'b0);
    endtask

    task wreg(input logic [4:0] r, input logic [7:0] a);
        go(PCB_OP_SEQ, 9'h000, a, 1'b1, r, 1'b0);
    endtask

    task t_reset;
        repeat (12) @(posedge clk);
        @(negedge clk);
        chk("pc", fetch_addr, PCB_RESET_VECTOR);
        chk("flush", flush, 1'b1);
        chk("status", status_flags, PCB_STATUS_RESET);
        chk("index", index_pointer, PCB_INDEX_RESET);
        chk("rom", instr, 12'h800);
        @(posedge clk);
        resetn <= 1'b1;
        @(negedge clk);
        seq;
        chk("pc", fetch_addr, 11'h000);
        chk("flush", flush, 1'b0);
        seq;
        chk("pc", fetch_addr, 11'h001);
    endtask

    // a call offered in the flush cycle must be dropped
    task t_jump;
        flow(PCB_OP_JUMP, 9'h1ff, 8'h00);
        flow(PCB_OP_CALL, 9'h0aa, 8'h00);
        chk("pc", fetch_addr, 11'h1ff);
        chk("flush", flush, 1'b1);
        seq;
        chk("pc", fetch_addr, 11'h200);
        chk("flush", flush, 1'b0);
    endtask

    // three nested calls overflow the two-level stack, then three returns
    task t_call;
        wreg(PCB_OFS_STATUS, 8'h20);
        flow(PCB_OP_JUMP, 9'h010, 8'h00);
        seq;
        chk("pc", fetch_addr, 11'h210);
        seq;
        flow(PCB_OP_CALL, 9'h1ab, 8'h00);
        chk("pc", fetch_addr, 11'h212);
        seq;
        chk("pc", fetch_addr, 11'h2ab);
        chk("flush", flush, 1'b1);
        seq;
        flow(PCB_OP_CALL, 9'h055, 8'h00);
        seq;
        seq;
        flow(PCB_OP_CALL, 9'h077, 8'h00);
        seq;
        chk("pc", fetch_addr, 11'h277);
        seq;
        flow(PCB_OP_RET, 9'h000, 8'h00);
        seq;
        chk("pc", fetch_addr, 11'h257);
        chk("flush", flush, 1'b1);
        seq;
        flow(PCB_OP_RET, 9'h000, 8'h00);
        seq;
        chk("pc", fetch_addr, 11'h2ad);
        // a third return finds the lost entry replaced, not the first caller
        seq;
        flow(PCB_OP_RET, 9'h000, 8'h00);
        seq;
        chk("pc", fetch_addr, 11'h2ad);
        // a return straight after the call's flush cycle
        flow(PCB_OP_CALL, 9'h033, 8'h00);
        seq;
        chk("pc", fetch_addr, 11'h233);
        flow(PCB_OP_RET, 9'h000, 8'h00);
        seq;
        chk("pc", fetch_addr, 11'h2ae);
    endtask

    task t_pcwr;
        wreg(PCB_OFS_STATUS, 8'h40);
        flow(PCB_OP_PCWR, 9'h000, 8'hc3);
        chk("status", status_flags, 8'h40);
        seq;
        chk("pc", fetch_addr, 11'h4c3);
        chk("pcl", program_counter_low, 8'hc3);
        chk("flush", flush, 1'b1);
        seq;
    endtask

    // every data bank: banked direct, shared direct, banked indirect
    task t_data;
        for (int b = 0; b < 4; b++)
        begin
            wreg(PCB_OFS_INDEX, {1'b0, b[1:0], 5'h1c});
            go(PCB_OP_SEQ, 9'h000, 8'h00, 1'b0, 5'h10, 1'b0);
            chk("index", index_pointer, {1'b0, b[1:0], 5'h1c});
            go(PCB_OP_SEQ, 9'h000, 8'h00, 1'b0, 5'h09, 1'b0);
            chk("daddr", data_addr, {b[1:0], 5'h10});
            go(PCB_OP_SEQ, 9'h000, 8'h00, 1'b0, 5'h00, 1'b1);
            chk("daddr", data_addr, 7'h09);
            seq;
            chk("daddr", data_addr, {b[1:0], 5'h1c});
            chk("reg", reg_data, {1'b0, b[1:0], 5'h1c} ^ 8'h5a);
        end
        // a pointer into the shared lower half falls back to bank zero
        wreg(PCB_OFS_INDEX, 8'h6a);
        go(PCB_OP_SEQ, 9'h000, 8'h00, 1'b0, 5'h00, 1'b1);
        seq;
        chk("daddr", data_addr, 7'h0a);
    endtask

    task test_done;
        if (err_count == 0 && tests_run > 0)
        begin
            $display("Result: passed");
        end
        else
        begin
            $display("Result: failed");
        end
        $finish;
    endtask

    initial
    begin
        t_reset;
        t_jump;
        t_call;
        t_pcwr;
        t_data;
        test_done;
    end

    // the run needs about 70 cycles; 400 means a hang
    initial
    begin
        #(400 * 100);
        err_count++;
        test_done;
    end
endmodule
`default_nettype wire
